// *** twc_regs.vh ***
// Register offsets, bit positions, status codes and timing for the two-wire controller
`ifndef TWC_REGS_VH
`define TWC_REGS_VH
`define TWC_ADDR_W 3
`define TWC_OFF_CTRL 3'h0
`define TWC_OFF_STAT 3'h1
`define TWC_OFF_DATA 3'h2
`define TWC_OFF_ADDR 3'h3
`define TWC_OFF_IRQ_STAT 3'h4
`define TWC_OFF_IRQ_MASK 3'h5
`define TWC_OFF_DIV 3'h6
// Control register bits
`define TWC_CTRL_FLAG 7
`define TWC_CTRL_ACKEN 6
`define TWC_CTRL_START 5
`define TWC_CTRL_STOP 4
`define TWC_CTRL_WCOL 3
`define TWC_CTRL_EN 2
// Interrupt status bits
`define TWC_IRQ_FLAG 0
`define TWC_IRQ_WCOL 1
`define TWC_IRQ_STOP 2
// Status codes, low three bits always zero
`define TWC_ST_START 8'h08
`define TWC_ST_RSTART 8'h10
`define TWC_ST_SLAW_ACK 8'h18
`define TWC_ST_SLAW_NACK 8'h20
`define TWC_ST_DATA_ACK 8'h28
`define TWC_ST_DATA_NACK 8'h30
`define TWC_ST_ARB_LOST 8'h38
`define TWC_ST_SLAR_ACK 8'h40
`define TWC_ST_SLAR_NACK 8'h48
`define TWC_ST_RDATA_ACK 8'h50
`define TWC_ST_RDATA_NACK 8'h58
`define TWC_ST_SR_ADDR 8'h60
`define TWC_ST_SR_DATA_ACK 8'h80
`define TWC_ST_SR_DATA_NACK 8'h88
`define TWC_ST_SR_STOP 8'ha0
`define TWC_ST_ST_ADDR 8'ha8
`define TWC_ST_ST_DATA_ACK 8'hb8
`define TWC_ST_ST_DATA_NACK 8'hc0
`define TWC_ST_IDLE 8'hf8
// Default quarter bit period minus one, in clocks
`define TWC_DIV_RST 8'h19
`endif

// *** twc_ctrl.v ***
// Two-wire bus controller: master byte engine with flag handshake; slave side only tracks foreign START and STOP
`timescale 1ns/1ps
`include "twc_regs.vh"

// What this block does
// R1: Supports master transmit and master receive modes; a foreign START only enters a slave state that waits for STOP.
// R2: Sets transfer-complete flag after byte sent and acknowledge bit sampled.
// R3: Holds the bus suspended while flag set; resumes when software writes it.
// R4: Presents a status code describing bus state whenever the flag is set.
// R5: Software masks status with f8 before comparing against codes.
// R6: Software writes flag, enable and stop together to end a master write.
// R7: Direction bit after address: high means read, low means write.
// R8: Acknowledge drives SDA low, not-acknowledge leaves SDA high, by receiver.
// R9: Each packet carries one 8-bit byte followed by one acknowledge bit.
// R10: Data write while flag low is discarded and sets write-collision bit.
// R11: After a requested STOP is sent, the stop-request bit clears itself.
// R12: Reset clears flag and stop request, sets status to idle (f8); bus starts idle, undriven.
module twc_ctrl
(
	input wire clk,
	input wire rst_n,
	input wire [`TWC_ADDR_W-1:0] addr,
	input wire [7:0] wdata,
	input wire wr,
	input wire rd,
	output reg [7:0] rdata_q,
	input wire scl_i,
	output reg scl_oe_q,
	input wire sda_i,
	output reg sda_oe_q,
	output reg irq_q
);
	localparam S_IDLE = 4'd0;
	localparam S_START = 4'd1;
	localparam S_BIT = 4'd2;
	localparam S_HOLD = 4'd3;
	localparam S_STOP = 4'd4;
	localparam S_SLAVE = 4'd5;

	reg [3:0] st_q;
	reg [7:0] div_q;
	reg [7:0] cnt_q;
	reg [1:0] ph_q;
	reg [3:0] bit_q;
	reg [7:0] sh_q;
	reg [7:0] data_q;
	reg [6:0] own_q;
	reg [7:0] stat_q;
	reg flag_q;
	reg acken_q;
	reg sta_q;
	reg sto_q;
	reg wcol_q;
	reg en_q;
	reg master_q;
	reg tx_q;
	reg first_q;
	reg [2:0] ist_q;
	reg [2:0] imask_q;
	reg scl_s_q;
	reg sda_s_q;
	reg sda_p_q;
	reg slv_q;
	wire tick = (cnt_q == 8'h00);
	wire ctrl_wr = wr && (addr == `TWC_OFF_CTRL);
	wire go = ctrl_wr && wdata[`TWC_CTRL_FLAG];
	wire set_flag = (st_q == S_BIT) && tick && (ph_q == 2'd3) && (bit_q == 4'd8);
	wire sto_done = (st_q == S_STOP) && tick && (ph_q == 2'd3);
	// Events: stop done, write collision, byte done
	wire [2:0] ev = {sto_done, wr && addr == `TWC_OFF_DATA && !flag_q, set_flag};
	// Foreign START: SDA falls while SCL high
	wire start_seen = scl_s_q && sda_p_q && !sda_s_q;
	// Bit being driven: tx data, or ack as receiver
	wire drive_bit = (bit_q == 4'd8) ? (tx_q ? 1'b1 : !acken_q) : (tx_q ? sh_q[7] : 1'b1);

	// Line sampling, plus previous SDA for edge detection
	always @(posedge clk)
	begin
		if (!rst_n)
		begin
			scl_s_q <= 1'b1;
			sda_s_q <= 1'b1;
			sda_p_q <= 1'b1;
		end
		else
		begin
			scl_s_q <= scl_i;
			sda_s_q <= sda_i;
			sda_p_q <= sda_s_q;
		end
	end

	// Register file
	always @(posedge clk)
	begin
		if (!rst_n)
		begin
			rdata_q <= 8'h00;
			div_q <= `TWC_DIV_RST;
			own_q <= 7'h00;
			data_q <= 8'h00;
			acken_q <= 1'b0;
			sta_q <= 1'b0;
			en_q <= 1'b0;
			wcol_q <= 1'b0;
			ist_q <= 3'h0;
			imask_q <= 3'h0;
			irq_q <= 1'b0;
		end
		else
		begin
			rdata_q <= 8'h00;
			if (rd)
			begin
				case (addr)
					`TWC_OFF_CTRL: rdata_q <= {flag_q, acken_q, sta_q, sto_q, wcol_q, en_q, 2'b00};
					`TWC_OFF_STAT: rdata_q <= stat_q; // [R4]
					`TWC_OFF_DATA: rdata_q <= data_q;
					`TWC_OFF_ADDR: rdata_q <= {own_q, 1'b0};
					`TWC_OFF_IRQ_STAT: rdata_q <= {5'h00, ist_q};
					`TWC_OFF_IRQ_MASK: rdata_q <= {5'h00, imask_q};
					`TWC_OFF_DIV: rdata_q <= div_q;
					default: rdata_q <= 8'h00;
				endcase
			end
			if (ctrl_wr)
			begin
				acken_q <= wdata[`TWC_CTRL_ACKEN];
				sta_q <= wdata[`TWC_CTRL_START];
				en_q <= wdata[`TWC_CTRL_EN];
			end
			else if (st_q == S_START && tick && ph_q == 2'd3)
				sta_q <= 1'b0;
			if (ev[1])
				wcol_q <= 1'b1; // [R10]
			else if (wr && addr == `TWC_OFF_DATA)
				wcol_q <= 1'b0;
			if (wr && addr == `TWC_OFF_DATA && flag_q)
				data_q <= wdata; // [R10]
			else if (set_flag && !tx_q)
				data_q <= sh_q;
			if (wr && addr == `TWC_OFF_ADDR)
				own_q <= wdata[7:1];
			if (wr && addr == `TWC_OFF_DIV)
				div_q <= wdata;
			if (wr && addr == `TWC_OFF_IRQ_MASK)
				imask_q <= wdata[2:0];
			// Set wins over write-one-to-clear
			ist_q <= (ist_q & ~((wr && addr == `TWC_OFF_IRQ_STAT) ? wdata[2:0] : 3'h0)) | ev;
			irq_q <= |(ist_q & imask_q);
		end
	end

	// Bus engine
	always @(posedge clk)
	begin
		if (!rst_n)
		begin
			st_q <= S_IDLE; // [R12]
			flag_q <= 1'b0;
			stat_q <= `TWC_ST_IDLE;
			sto_q <= 1'b0;
			scl_oe_q <= 1'b0;
			sda_oe_q <= 1'b0;
			cnt_q <= 8'h00;
			ph_q <= 2'd0;
			bit_q <= 4'd0;
			sh_q <= 8'h00;
			master_q <= 1'b0;
			tx_q <= 1'b0;
			first_q <= 1'b0;
			slv_q <= 1'b0;
		end
		else
		begin
			cnt_q <= tick ? div_q : cnt_q - 8'h01;
			if (tick)
				ph_q <= ph_q + 2'd1;
			if (go)
				flag_q <= 1'b0; // [R3]
			// Stop request lives until the STOP is on the bus
			if (ctrl_wr && wdata[`TWC_CTRL_STOP])
				sto_q <= 1'b1; // [R6]
			if (sto_done)
				sto_q <= 1'b0; // [R11]
			case (st_q)
				S_IDLE:
				begin
					scl_oe_q <= 1'b0;
					sda_oe_q <= 1'b0;
					ph_q <= 2'd0;
					if (en_q && sta_q && !flag_q && scl_s_q && sda_s_q)
						st_q <= S_START;
					else if (en_q && start_seen)
					begin
						st_q <= S_SLAVE; // [R1]
						bit_q <= 4'd0;
					end
				end
				S_START:
				if (tick)
				begin
					// Quarter steps: release, SDA low, SCL low
					sda_oe_q <= (ph_q != 2'd0);
					scl_oe_q <= (ph_q == 2'd3);
					if (ph_q == 2'd3)
					begin
						flag_q <= 1'b1;
						stat_q <= master_q ? `TWC_ST_RSTART : `TWC_ST_START;
						master_q <= 1'b1; // [R1]
						first_q <= 1'b1;
						tx_q <= 1'b1;
						st_q <= S_HOLD;
					end
				end
				S_HOLD:
				begin
					ph_q <= 2'd0;
					if (!flag_q && !go) // [R3]
					begin
						if (!master_q)
							st_q <= S_IDLE;
						else if (sto_q)
							st_q <= S_STOP;
						else if (sta_q)
							st_q <= S_START;
						else
						begin
							sh_q <= data_q;
							bit_q <= 4'd0;
							st_q <= S_BIT;
						end
					end
				end
				S_BIT:
				if (tick)
				begin
					// Quarter 0 sets SDA, 1 raises SCL, 2 samples, 3 lowers SCL
					case (ph_q)
						// Transmit shifts MSB first; receive fills sh_q
						2'd0: sda_oe_q <= !drive_bit; // [R8]
						2'd1: scl_oe_q <= 1'b0;
						2'd2:
						begin
							if (bit_q != 4'd8)
								sh_q <= {sh_q[6:0], sda_s_q};
							else if (first_q)
								tx_q <= !data_q[0]; // [R7]
							if (tx_q && bit_q != 4'd8 && sh_q[7] && !sda_s_q)
							begin
								stat_q <= `TWC_ST_ARB_LOST;
								master_q <= 1'b0;
							end
						end
						default:
						begin
							scl_oe_q <= 1'b1;
							bit_q <= bit_q + 4'd1; // [R9]
							if (bit_q == 4'd8)
							begin
								flag_q <= 1'b1; // [R2]
								first_q <= 1'b0;
								st_q <= S_HOLD;
								if (stat_q != `TWC_ST_ARB_LOST)
									stat_q <= first_q
										? (data_q[0] ? (sda_s_q ? `TWC_ST_SLAR_NACK : `TWC_ST_SLAR_ACK)
										: (sda_s_q ? `TWC_ST_SLAW_NACK : `TWC_ST_SLAW_ACK))
										: (tx_q ? (sda_s_q ? `TWC_ST_DATA_NACK : `TWC_ST_DATA_ACK)
										: (acken_q ? `TWC_ST_RDATA_ACK : `TWC_ST_RDATA_NACK));
							end
						end
					endcase
				end
				S_STOP:
				if (tick)
				begin
					// SDA low, SCL high, then SDA released
					sda_oe_q <= (ph_q != 2'd3);
					scl_oe_q <= (ph_q == 2'd0);
					if (ph_q == 2'd3)
					begin
						master_q <= 1'b0;
						stat_q <= `TWC_ST_IDLE;
						st_q <= S_IDLE;
					end
				end
				S_SLAVE:
				begin
					// Slave state following a foreign START: waits for STOP, no bytes received or sent
					if (scl_s_q && !sda_p_q && sda_s_q)
					begin
						flag_q <= slv_q;
						stat_q <= `TWC_ST_SR_STOP;
						sda_oe_q <= 1'b0;
						slv_q <= 1'b0;
						st_q <= S_IDLE;
					end
					else if (!flag_q && scl_oe_q)
						scl_oe_q <= 1'b0;
				end
				default: st_q <= S_IDLE;
			endcase
		end
	end
endmodule

// *** twc_ctrl_assertions.sv ***
// Port assertions for the two-wire controller
`timescale 1ns/1ps
module twc_ctrl_assertions
(
	input wire clk,
	input wire rst_n,
	input wire [2:0] addr,
	input wire [7:0] wdata,
	input wire wr,
	input wire rd,
	input wire [7:0] rdata_q,
	input wire scl_oe_q,
	input wire sda_oe_q,
	input wire irq_q
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	a_reset_quiet: assert property (disable iff (1'b0) !rst_n |=> !scl_oe_q && !sda_oe_q)
		else $error("bus driven in reset");
	a_read_idle: assert property (!$past(rd) |-> !rdata_q) else $error("stray data");
	a_stat_low: assert property ($past(rd && addr == 3'h1) |-> !rdata_q[2:0])
		else $error("status bits");
	a_ctrl_low: assert property ($past(rd && addr == 3'h0) |-> !rdata_q[1:0])
		else $error("ctrl bits");
	a_irq_bits: assert property ($past(rd && addr == 3'h4) |-> !rdata_q[7:3])
		else $error("irq bits");
	a_mask_off: assert property (wr && addr == 3'h5 && !wdata ##1 !wr |=> !irq_q)
		else $error("masked irq");
	a_stop_idle: assert property ($fell(sda_oe_q) && !scl_oe_q |=> !sda_oe_q [*4])
		else $error("busy after stop");
	a_start_hold: assert property ($rose(sda_oe_q) && !scl_oe_q |=> sda_oe_q [*4])
		else $error("short start");
	cover property ($fell(sda_oe_q) && !scl_oe_q);
	cover property ($rose(sda_oe_q) && !scl_oe_q);
	cover property ($rose(irq_q));
endmodule

bind twc_ctrl twc_ctrl_assertions i_chk (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
	.wr(wr), .rd(rd), .rdata_q(rdata_q), .scl_oe_q(scl_oe_q), .sda_oe_q(sda_oe_q), .irq_q(irq_q));

// *** twc_slave_model.sv ***
// Receiving bus agent
`timescale 1ns/1ps
module twc_slave_model
(
	input wire scl,
	input wire sda,
	input wire nack,
	output reg sda_oe = 1'b0,
	output reg [7:0] rx_q
);
	integer n = 0;
	// START restarts the count
	always @(negedge sda)
		if (scl)
			n = -1;
	always @(posedge scl)
		if (n < 8)
			rx_q <= {rx_q[6:0], sda};
	always @(negedge scl)
	begin
		n = (n == 8) ? 0 : n + 1;
		sda_oe <= n == 8 && !nack;
	end
endmodule

// *** twc_ctrl_test.sv ***
// Bench for the two-wire controller
`timescale 1ns/1ps
module twc_ctrl_test;
	logic clk = 0, rst_n = 0, wr = 0, rd = 0, nack = 0;
	logic [2:0] addr = 0;
	logic [7:0] wdata = 0, v;
	wire [7:0] rdata_q, rx;
	wire scl_oe_q, sda_oe_q, irq_q, m_oe;
	wire scl = !scl_oe_q;
	wire sda = !(sda_oe_q || m_oe);
	wire [7:0] oe = {6'h0, scl_oe_q, sda_oe_q};
	int fails = 0, n_tests = 0;
	logic [23:0] t [6] = '{24'h00a408, 24'ha08418, 24'h3c8428, 24'h5a8430, 24'h00a410, 24'ha18440};
	twc_ctrl i_dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata_q(rdata_q), .scl_i(scl), .scl_oe_q(scl_oe_q), .sda_i(sda), .sda_oe_q(sda_oe_q),
		.irq_q(irq_q));
	twc_slave_model i_slv (.scl(scl), .sda(sda), .nack(nack), .sda_oe(m_oe), .rx_q(rx));
	initial forever #12.5 clk = !clk;
	task automatic tally_and_finish();
		$display("checks %0d fails %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(string s, logic [7:0] e, logic [7:0] g);
		n_tests++;
		if (g !== e)
		begin
			fails++;
			$display("wrong value %s exp %h got %h", s, e, g);
		end
	endtask
	task automatic bus(logic w, logic [2:0] a, logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= w;
		rd <= !w;
		@(posedge clk);
		wr <= 1'b0;
		rd <= 1'b0;
		#1 v = rdata_q;
	endtask
	task automatic rchk(string s, logic [2:0] a, logic [7:0] m, logic [7:0] e);
		bus(1'b0, a, 8'h0);
		chk(s, e, v & m);
	endtask
	task automatic await(logic [7:0] m, logic [7:0] e);
		for (int i = 0; i < 1000; i++)
		begin
			bus(1'b0, 3'h0, 8'h0);
			if ((v & m) === e)
				return;
		end
		fails++;
		tally_and_finish();
	endtask
	initial
	begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		rchk("reset status", 3'h1, 8'hff, 8'hf8);
		rchk("reset ctrl", 3'h0, 8'hff, 8'h00);
		chk("reset lines", 8'h0, oe);
		foreach (t[i])
		begin
			nack <= t[i][7:0] == 8'h30;
			if (t[i][23:16] != 8'h0)
				bus(1'b1, 3'h2, t[i][23:16]);
			bus(1'b1, 3'h0, t[i][15:8]);
			await(8'h80, 8'h80);
			rchk("status", 3'h1, 8'hf8, t[i][7:0]);
			if (t[i][23:16] != 8'h0)
				chk("byte", t[i][23:16], rx);
			v = oe;
			repeat (300) @(posedge clk);
			chk("held", v, oe);
		end
		bus(1'b1, 3'h0, 8'h94);
		await(8'h10, 8'h00);
		chk("free", 8'h0, oe);
		bus(1'b1, 3'h2, 8'h77);
		rchk("wcol", 3'h0, 8'h08, 8'h08);
		bus(1'b1, 3'h5, 8'h02);
		rchk("irq", 3'h4, 8'hff, 8'h07);
		chk("irq pin", 8'h01, {7'h0, irq_q});
		bus(1'b1, 3'h5, 8'h00);
		bus(1'b1, 3'h4, 8'h07);
		rchk("clear", 3'h4, 8'hff, 8'h00);
		bus(1'b1, 3'h5, 8'h07);
		bus(1'b1, 3'h0, 8'ha4);
		repeat (60) @(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		rchk("mid reset status", 3'h1, 8'hff, 8'hf8);
		chk("mid reset lines", 8'h0, oe);
		chk("mid reset irq", 8'h00, {7'h0, irq_q});
		tally_and_finish();
	end
endmodule
